// ### ppoc_monitor.sv
// Board side of one pin: power switch input and open-drain current monitor
`timescale 1ns/1ps
`default_nettype none
module ppoc_monitor (
   input wire logic oe,
   input wire logic out,
   input wire logic pu,
   input wire logic fault,
   output logic pin
);
   // Monitor can only pull low; with no pull-up and no driver the pin reads low
   assign pin = oe ? out : (pu && !fault);
endmodule
`default_nettype wire

// ### ppoc_pkg.sv
// Package for the downstream port power / overcurrent control block.
// Assumes a single 40 MHz core clock domain.
package ppoc_pkg;
   localparam int PPOC_NPORTS = 3;
   localparam int PPOC_SYNC_STAGES = 3;
   localparam logic [2:0] PPOC_SPLIT_CAPABLE = 3'h3;
   localparam logic [2:0] PPOC_SYNC_RESET = 3'h7;
   localparam logic PPOC_OC_RESET = 1'h0;
   localparam logic PPOC_EN_RESET = 1'h0;
   // Edges after enable before the synchronised level can show the pull-up
   localparam logic [2:0] PPOC_SETTLE_CYCLES = 3'h4;
   localparam logic [2:0] PPOC_SETTLE_RESET = 3'h0;

   typedef struct packed {
      logic in;
      logic out;
      logic oe;
      logic pullup_en;
   } ppoc_pin_t;

   typedef struct packed {
      logic u2_power_en;
      logic u3_power_en;
      logic u2_overcurrent;
      logic u3_overcurrent;
   } ppoc_port_stat_t;
endpackage

// ### ppoc_port_ctl.sv
// Power enable and overcurrent sense for downstream ports 4, 5 and 6.
// Assumes hub configuration and host port-power requests arrive on clk.
`timescale 1ns/1ps
`default_nettype none
// Functional notes
// - Enabled port: pin released, pull-up on
// - Pulled-up high enables external power switch
// - Low on enabled pin means overcurrent
// - Disabled port: pin driven low
// - Ports 4,5 unsplit: pin governs both halves
// - Ports 4,5 split: pin governs USB2 only
// - Port 6 always governs both halves
module ppoc_port_ctl
   import ppoc_pkg::*;
(
   input wire logic clk,
   input wire logic rst,
   input wire logic [2:0] cfg_port_en,
   input wire logic [2:0] host_port_power,
   input wire logic [1:0] split_port_option,
   input wire logic [2:0] oc_clear,
   input wire logic port4_power_sense_pin_in,
   output logic port4_power_sense_pin_out,
   output logic port4_power_sense_pin_oe,
   output logic port4_power_sense_pin_pu,
   input wire logic port5_power_sense_pin_in,
   output logic port5_power_sense_pin_out,
   output logic port5_power_sense_pin_oe,
   output logic port5_power_sense_pin_pu,
   input wire logic port6_power_sense_pin_in,
   output logic port6_power_sense_pin_out,
   output logic port6_power_sense_pin_oe,
   output logic port6_power_sense_pin_pu,
   output ppoc_port_stat_t [2:0] port_stat
);
   // ------------------------------------------------------------
   // Pin gathering
   // ------------------------------------------------------------
   logic [2:0] pin_in;
   logic [2:0] pin_lvl;
   logic [2:0] split_eff;
   ppoc_pin_t [2:0] pin;

   assign pin_in = {port6_power_sense_pin_in, port5_power_sense_pin_in, port4_power_sense_pin_in};
   // Port 6 has no split capability, so its bit is forced off
   assign split_eff = {1'h0, split_port_option} & PPOC_SPLIT_CAPABLE;

   genvar g;
   generate
      for (g = 0; g < PPOC_NPORTS; g++) begin : g_sync
         ppoc_sync u_sync (
            .clk(clk),
            .rst(rst),
            .din(pin_in[g]),
            .dout(pin_lvl[g])
         );
      end
   endgenerate

   // ------------------------------------------------------------
   // Enable and overcurrent state
   // ------------------------------------------------------------
   logic [2:0] en_r;
   logic [2:0] en_nxt;
   logic [2:0] oc_r;
   logic [2:0] oc_nxt;
   logic [PPOC_NPORTS-1:0][2:0] settle_r;
   logic [PPOC_NPORTS-1:0][2:0] settle_nxt;
   logic [2:0] sense_ok;

   always_comb begin
      en_nxt = cfg_port_en & host_port_power;
      settle_nxt = settle_r;
      sense_ok = 3'h0;
      for (int i = 0; i < PPOC_NPORTS; i++) begin
         // Pin was held low while disabled; the sync path still shows that low for a few edges
         if (!en_r[i]) begin
            settle_nxt[i] = PPOC_SETTLE_RESET;
         end else if (settle_r[i] != PPOC_SETTLE_CYCLES) begin
            settle_nxt[i] = settle_r[i] + 3'h1;
         end
         sense_ok[i] = en_r[i] && (settle_r[i] == PPOC_SETTLE_CYCLES);
      end
      // Set wins over clear so an event in the clear cycle is kept
      oc_nxt = (oc_r & ~oc_clear) | (sense_ok & ~pin_lvl);
   end

   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         en_r <= {3{PPOC_EN_RESET}};
         oc_r <= {3{PPOC_OC_RESET}};
         settle_r <= {PPOC_NPORTS{PPOC_SETTLE_RESET}};
      end else begin
         en_r <= en_nxt;
         oc_r <= oc_nxt;
         settle_r <= settle_nxt;
      end
   end

   // ------------------------------------------------------------
   // Pin drive and port status
   // ------------------------------------------------------------
   always_comb begin
      for (int i = 0; i < PPOC_NPORTS; i++) begin
         pin[i].in = pin_in[i];
         pin[i].out = 1'h0;
         pin[i].oe = ~en_r[i];
         pin[i].pullup_en = en_r[i];
         port_stat[i].u2_power_en = en_r[i];
         port_stat[i].u2_overcurrent = oc_r[i];
         if (split_eff[i]) begin
            // Split: USB 3.2 half is left to its own control
            port_stat[i].u3_power_en = 1'h0;
            port_stat[i].u3_overcurrent = 1'h0;
         end else begin
            port_stat[i].u3_power_en = en_r[i];
            port_stat[i].u3_overcurrent = oc_r[i];
         end
      end
   end

   assign port4_power_sense_pin_out = pin[0].out;
   assign port4_power_sense_pin_oe = pin[0].oe;
   assign port4_power_sense_pin_pu = pin[0].pullup_en;
   assign port5_power_sense_pin_out = pin[1].out;
   assign port5_power_sense_pin_oe = pin[1].oe;
   assign port5_power_sense_pin_pu = pin[1].pullup_en;
   assign port6_power_sense_pin_out = pin[2].out;
   assign port6_power_sense_pin_oe = pin[2].oe;
   assign port6_power_sense_pin_pu = pin[2].pullup_en;
endmodule
`default_nettype wire

// ### ppoc_port_ctl_sva.sv
// Checker on port 4 pin and on status of ports 4 and 6
`timescale 1ns/1ps
`default_nettype none
module ppoc_port_ctl_sva import ppoc_pkg::*; (
   input wire logic clk,
   input wire logic rst,
   input wire logic [2:0] cfg_port_en,
   input wire logic [2:0] host_port_power,
   input wire logic [1:0] split_port_option,
   input wire logic [2:0] oc_clear,
   input wire logic port4_power_sense_pin_in,
   input wire logic port4_power_sense_pin_oe,
   input wire logic port4_power_sense_pin_pu,
   input wire ppoc_port_stat_t [2:0] port_stat
);
   wire logic en = cfg_port_en[0] & host_port_power[0];
   wire logic pu = port4_power_sense_pin_pu;
   wire logic [3:0] s = port_stat[0];
   wire logic [3:0] t = port_stat[2];
   default clocking @(posedge clk); endclocking
   default disable iff (rst);
   a_pullup_follows: assert property (!$past(rst) |-> pu == $past(en))
      else $error("pull-up");
   a_drive_disabled: assert property (!$past(rst) |-> port4_power_sense_pin_oe == !$past(en))
      else $error("drive");
   a_oc_sensed: assert property ((pu && !port4_power_sense_pin_in) [*7] |-> s[1])
      else $error("sense");
   // Blanking and pipeline mean an enabled window must precede any new flag
   a_oc_enabled: assert property ($rose(s[1]) |-> $past(pu) && $past(pu, 4))
      else $error("blank");
   a_oc_sticky: assert property (s[1] && !oc_clear[0] |=> s[1])
      else $error("sticky");
   a_split_u2only: assert property (split_port_option[0] |-> !s[2] && !s[0])
      else $error("split");
   a_joint_halves: assert property (!split_port_option[0] |-> s[3] == s[2] && s[1] == s[0])
      else $error("joint");
   a_port6_both: assert property (t[3] == t[2] && t[1] == t[0])
      else $error("port6");
endmodule
bind ppoc_port_ctl ppoc_port_ctl_sva chk (.*);
`default_nettype wire

// ### ppoc_sync.sv
// Three-flop synchroniser with agreement filter for one pin input.
// Assumes the input is asynchronous to clk.
`timescale 1ns/1ps
`default_nettype none
module ppoc_sync
   import ppoc_pkg::*;
(
   input wire logic clk,
   input wire logic rst,
   input wire logic din,
   output logic dout
);
   logic [2:0] sync_r;
   logic [2:0] sync_nxt;
   logic level_r;
   logic level_nxt;

   always_comb begin
      sync_nxt = {sync_r[1:0], din};
      level_nxt = level_r;
      // Stage two and three must agree before the level moves
      if (sync_r[1] == sync_r[2]) begin
         level_nxt = sync_r[2];
      end
   end

   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         sync_r <= PPOC_SYNC_RESET;
         level_r <= 1'h1;
      end else begin
         sync_r <= sync_nxt;
         level_r <= level_nxt;
      end
   end

   assign dout = level_r;
endmodule
`default_nettype wire

// ### test_port_power_overcurrent_ctl.sv
// Bench for ppoc_port_ctl, one board monitor per pin
`timescale 1ns/1ps
`default_nettype none
module test_port_power_overcurrent_ctl import ppoc_pkg::*; ;
   logic clk = 0, rst = 1;
   logic [2:0] cfg = 0, host = 0, clr = 0, fault = 0;
   logic [1:0] split = 0;
   wire logic [2:0] pin, out, oe, pu;
   wire ppoc_port_stat_t [2:0] stat;
   int n_errors = 0, cmp_count = 0, cyc = 0;
   ppoc_port_ctl DUT (.clk(clk), .rst(rst), .cfg_port_en(cfg), .host_port_power(host),
      .split_port_option(split), .oc_clear(clr), .port_stat(stat),
      .port4_power_sense_pin_in(pin[0]), .port4_power_sense_pin_out(out[0]),
      .port4_power_sense_pin_oe(oe[0]), .port4_power_sense_pin_pu(pu[0]),
      .port5_power_sense_pin_in(pin[1]), .port5_power_sense_pin_out(out[1]),
      .port5_power_sense_pin_oe(oe[1]), .port5_power_sense_pin_pu(pu[1]),
      .port6_power_sense_pin_in(pin[2]), .port6_power_sense_pin_out(out[2]),
      .port6_power_sense_pin_oe(oe[2]), .port6_power_sense_pin_pu(pu[2]));
   ppoc_monitor mon[2:0] (.oe(oe), .out(out), .pu(pu), .fault(fault), .pin(pin));
   task automatic complete_run();
      if (n_errors == 0 && cmp_count > 0) $display("== PASSED ==");
      else $display("== FAILED ==");
      $finish;
   endtask
   task automatic chk(input logic [4:0] g, input logic [4:0] e);
      cmp_count++;
      if (g !== e) begin
         n_errors++;
         $display("mismatch %0t got %h exp %h", $time, g, e);
      end
   endtask
   task automatic t_power(input int p);
      cfg = 3'h7;
      host[p] = 1'b0;
      repeat (2) @(negedge clk);
      chk({oe[p], pu[p], pin[p], stat[p][3], stat[p][1]}, 5'h10);
      host[p] = 1'b1;
      repeat (2) @(negedge clk);
      chk({oe[p], pu[p], pin[p], stat[p][3], stat[p][1]}, 5'h0E);
      repeat (6) @(negedge clk);
      chk({oe[p], pu[p], pin[p], stat[p][3], stat[p][1]}, 5'h0E);
      cfg[p] = 1'b0;
      repeat (2) @(negedge clk);
      chk({oe[p], pu[p], pin[p], stat[p][3], stat[p][1]}, 5'h10);
      cfg[p] = 1'b1;
   endtask
   // Clear is held past the sense pipeline, since a pending set beats it
   task automatic t_oc(input int p, input logic sp);
      logic two;
      two = sp && p < 2;
      split = {2{sp}};
      repeat (8) @(negedge clk);
      fault[p] = 1'b1;
      repeat (8) @(negedge clk);
      chk({1'b0, stat[p]}, two ? 5'h0A : 5'h0F);
      fault[p] = 1'b0;
      clr[p] = 1'b1;
      repeat (8) @(negedge clk);
      chk({1'b0, stat[p]}, two ? 5'h08 : 5'h0C);
      clr[p] = 1'b0;
   endtask
   initial begin
      forever #12.5 clk = ~clk;
   end
   always @(posedge clk) begin
      cyc++;
      if (cyc == 1000) begin
         n_errors++;
         complete_run();
      end
   end
   initial begin
      repeat (6) @(negedge clk);
      rst = 0;
      host = 3'h7;
      for (int p = 0; p < 3; p++) t_power(p);
      for (int p = 0; p < 6; p++) t_oc(p % 3, p > 2);
      complete_run();
   end
endmodule
`default_nettype wire
